// [rtl/cal_params.svh]
// constants for the calendar and alarm register slice
// assumes a 5-bit register address as seen behind the serial interface
`ifndef CAL_PARAMS_SVH
`define CAL_PARAMS_SVH

// primary and mirrored register addresses
`define CAL_MONTH_ADR     5'h05
`define CAL_YEAR_ADR      5'h06
`define CAL_RAM_ADR       5'h07
`define CAL_MIN_AL_ADR    5'h08
`define CAL_HR_AL_ADR     5'h09
`define CAL_MONTH_MIR     5'h16
`define CAL_YEAR_MIR      5'h17
`define CAL_MIN_AL_MIR    5'h18
`define CAL_HR_AL_MIR     5'h19

// reset values
`define CAL_MONTH_RST     5'h01
`define CAL_YEAR_RST      8'h00
`define CAL_BYTE_RST      8'h00

// field positions
`define CAL_TOP_BIT       7
`define CAL_DIS_BIT       7
`define CAL_SPARE_BIT     6
`define CAL_MONTH_MSB     4
`define CAL_MIN_MSB       6
`define CAL_HR_MSB        5

// calendar limits, bcd
`define CAL_MONTH_FIRST   5'h01
`define CAL_MONTH_LAST    5'h12
`define CAL_FEB           5'h02
`define CAL_APR           5'h04
`define CAL_JUN           5'h06
`define CAL_SEP           5'h09
`define CAL_NOV           5'h11
`define CAL_YEAR_LAST     8'h99
`define CAL_DAYS_31       6'h31
`define CAL_DAYS_30       6'h30
`define CAL_DAYS_29       6'h29
`define CAL_DAYS_28       6'h28
`define CAL_DIGIT_NINE    4'h9
`define CAL_DIGIT_ZERO    4'h0

`endif

// [rtl/cal_pkg.sv]
// types shared by the calendar and alarm register slice
// assumes cal_params.svh supplies the numeric constants
package cal_pkg;

   // register access request from the serial interface front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } cal_req_t;

   // current time from the minute and hour counters
   typedef struct packed {
      logic [6:0] minute;
      logic [5:0] hour;
   } cal_time_t;

   typedef enum logic [2:0] {
      CAL_SEL_NONE  = 3'h0,
      CAL_SEL_MONTH = 3'h1,
      CAL_SEL_YEAR  = 3'h2,
      CAL_SEL_RAM   = 3'h3,
      CAL_SEL_MIN   = 3'h4,
      CAL_SEL_HR    = 3'h5
   } cal_sel_t;

endpackage : cal_pkg

// [rtl/cal_regs.sv]
// month, year, user byte and minute/hour alarm registers
// assumes the serial front end and time counters run on sys_clk
// How it works
// (RL1) month is bcd in bits 4:0, 01 to 12, bits 7:5 read zero
// (RL2) year is eight-bit bcd 00 to 99 using all bits
// (RL3) years are 2000 to 2099, leap when year divisible by four
// (RL4) each register at 05h-09h except the user byte at 07h also answers at its 16h-19h mirror
// (RL5) user byte at 07h stores anything, no side effect, resets zero
// (RL6) minute alarm bit 7 set drops minute from alarm matching
// (RL7) minute alarm bits 6:0 hold target minute, reset zero
// (RL8) hour alarm bit 7 set drops hour from alarm matching
// (RL9) hour alarm bit 6 is a spare storage bit, reset zero
// (RL10) hour alarm bits 5:0 hold target hour, reset zero
// (RL11) alarm fires on minute update when all enabled fields match
// (RL12) host loads valid month and year after power-on
`timescale 1ns/1ps
`include "cal_params.svh"

module cal_regs
   import cal_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire cal_req_t   req,
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   input  wire cal_time_t  now,
   input  wire logic       minute_tick,
   input  wire logic       month_roll,
   input  wire logic       day_alarm_ok,
   output logic            alarm_event,
   output logic            leap_year,
   output logic [5:0]      days_in_month,
   output logic [4:0]      month,
   output logic [7:0]      year
);

   logic [4:0]  month_count;
   logic [7:0]  year_count;
   logic [7:0]  user_byte;
   logic [7:0]  minute_alarm;
   logic [7:0]  hour_alarm;
   logic [4:0]  next_month_count;
   logic [7:0]  next_year_count;
   logic [7:0]  next_user_byte;
   logic [7:0]  next_minute_alarm;
   logic [7:0]  next_hour_alarm;
   logic [7:0]  next_rd_data;
   logic        next_rd_valid;
   logic        next_alarm_event;
   cal_sel_t    wr_sel;
   cal_sel_t    rd_sel;
   logic        min_ok;
   logic        hr_ok;

   // both address ranges decode to one register, so mirrors never drift
   function automatic cal_sel_t decode(input logic [4:0] a);
      cal_sel_t s;
      s = CAL_SEL_NONE;
      if (a == `CAL_MONTH_ADR || a == `CAL_MONTH_MIR)
         s = CAL_SEL_MONTH;
      else if (a == `CAL_YEAR_ADR || a == `CAL_YEAR_MIR)
         s = CAL_SEL_YEAR;
      else if (a == `CAL_RAM_ADR)
         s = CAL_SEL_RAM;
      else if (a == `CAL_MIN_AL_ADR || a == `CAL_MIN_AL_MIR)
         s = CAL_SEL_MIN;
      else if (a == `CAL_HR_AL_ADR || a == `CAL_HR_AL_MIR)
         s = CAL_SEL_HR;
      return s;
   endfunction : decode

   // two-digit bcd increment, no wrap beyond 99
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      r = v;
      if (v[3:0] == `CAL_DIGIT_NINE)
      begin
         r[3:0] = `CAL_DIGIT_ZERO;
         r[7:4] = v[7:4] + 4'h1;
      end
      else
         r[3:0] = v[3:0] + 4'h1;
      return r;
   endfunction : bcd_inc

   // in 2000..2099 every year divisible by four is leap, 2000 included
   function automatic logic bcd_leap(input logic [7:0] y);
      logic l;
      if (y[4])
         l = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      else
         l = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      return l;
   endfunction : bcd_leap

   assign wr_sel = req.wr ? decode(req.addr) : CAL_SEL_NONE;
   assign rd_sel = req.rd ? decode(req.addr) : CAL_SEL_NONE;
   assign month  = month_count;
   assign year   = year_count;

   // month length for the date counter outside
   always_comb
   begin
      leap_year = bcd_leap(year_count); // RL3
      if (month_count == `CAL_FEB)
         days_in_month = leap_year ? `CAL_DAYS_29 : `CAL_DAYS_28; // RL3
      else if (month_count == `CAL_APR || month_count == `CAL_JUN ||
               month_count == `CAL_SEP || month_count == `CAL_NOV)
         days_in_month = `CAL_DAYS_30;
      else
         days_in_month = `CAL_DAYS_31;
   end

   // disabled fields count as matching
   assign min_ok = minute_alarm[`CAL_DIS_BIT] ||
                   (now.minute == minute_alarm[`CAL_MIN_MSB:0]); // RL6 RL7
   assign hr_ok  = hour_alarm[`CAL_DIS_BIT] ||
                   (now.hour == hour_alarm[`CAL_HR_MSB:0]); // RL8 RL10

   always_comb
   begin
      next_month_count  = month_count;
      next_year_count   = year_count;
      next_user_byte    = user_byte;
      next_minute_alarm = minute_alarm;
      next_hour_alarm   = hour_alarm;
      next_rd_valid     = req.rd;
      next_rd_data      = rd_data;
      next_alarm_event  = minute_tick && min_ok && hr_ok &&
                          day_alarm_ok; // RL11
      // calendar advance; a host write in the same cycle wins below
      if (month_roll)
      begin
         if (month_count == `CAL_MONTH_LAST)
         begin
            next_month_count = `CAL_MONTH_FIRST; // RL1
            if (year_count == `CAL_YEAR_LAST)
               next_year_count = `CAL_YEAR_RST; // RL2
            else
               next_year_count = bcd_inc(year_count); // RL2
         end
         else
         begin
            next_month_count = 5'(bcd_inc({3'h0, month_count})); // RL1
         end
      end
      unique case (wr_sel)
         CAL_SEL_MONTH:
            next_month_count = req.wdata[`CAL_MONTH_MSB:0]; // RL1 RL4
         CAL_SEL_YEAR:
            next_year_count = req.wdata; // RL2 RL4
         CAL_SEL_RAM:
            next_user_byte = req.wdata; // RL5
         CAL_SEL_MIN:
            next_minute_alarm = req.wdata; // RL6 RL7 RL4
         CAL_SEL_HR:
            next_hour_alarm = req.wdata; // RL8 RL9 RL10 RL4
         CAL_SEL_NONE:
            next_minute_alarm = minute_alarm;
      endcase
      // read data from the same decode; unmapped reads as zero
      if (req.rd)
      begin
         unique case (rd_sel)
            CAL_SEL_MONTH:
               next_rd_data = {3'h0, month_count}; // RL1
            CAL_SEL_YEAR:
               next_rd_data = year_count;
            CAL_SEL_RAM:
               next_rd_data = user_byte;
            CAL_SEL_MIN:
               next_rd_data = minute_alarm;
            CAL_SEL_HR:
               next_rd_data = hour_alarm; // RL9
            CAL_SEL_NONE:
               next_rd_data = `CAL_BYTE_RST;
         endcase
      end
   end

   // month resets to 01 and year to 00; the real date is loaded by the host
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         month_count  <= `CAL_MONTH_RST; // RL12
         year_count   <= `CAL_YEAR_RST; // RL12
         user_byte    <= `CAL_BYTE_RST; // RL5
         minute_alarm <= `CAL_BYTE_RST; // RL6 RL7
         hour_alarm   <= `CAL_BYTE_RST; // RL8 RL9 RL10
         rd_data      <= `CAL_BYTE_RST;
         rd_valid     <= 1'b0;
         alarm_event  <= 1'b0;
      end
      else
      begin
         month_count  <= next_month_count;
         year_count   <= next_year_count;
         user_byte    <= next_user_byte;
         minute_alarm <= next_minute_alarm;
         hour_alarm   <= next_hour_alarm;
         rd_data      <= next_rd_data;
         rd_valid     <= next_rd_valid;
         alarm_event  <= next_alarm_event;
      end
   end

   month_read_zero_a: assert property ( // RL1
      @(posedge sys_clk) disable iff (rst)
      rd_valid && $past(rd_sel) == CAL_SEL_MONTH |->
         rd_data[`CAL_TOP_BIT:`CAL_MONTH_MSB+1] == '0 &&
         rd_data[`CAL_MONTH_MSB:0] == $past(month_count))
      else $error("month read shows wrong bits");

   month_write_a: assert property ( // RL1
      @(posedge sys_clk) disable iff (rst)
      req.wr && (req.addr == `CAL_MONTH_ADR || req.addr == `CAL_MONTH_MIR)
      |=> month_count == $past(req.wdata[`CAL_MONTH_MSB:0]))
      else $error("month write not stored");

   year_wrap_a: assert property ( // RL2
      @(posedge sys_clk) disable iff (rst)
      month_roll && !req.wr && month_count == `CAL_MONTH_LAST &&
      year_count == `CAL_YEAR_LAST |=>
         year_count == `CAL_YEAR_RST && month_count == `CAL_MONTH_FIRST)
      else $error("year did not wrap to 00");

   year_write_a: assert property ( // RL2
      @(posedge sys_clk) disable iff (rst)
      req.wr && (req.addr == `CAL_YEAR_ADR || req.addr == `CAL_YEAR_MIR)
      |=> year_count == $past(req.wdata))
      else $error("year write not stored");

   // reference uses decimal arithmetic, independent of the digit decode
   leap_span_a: assert property ( // RL3
      @(posedge sys_clk) disable iff (rst)
      month_count == `CAL_FEB |->
         days_in_month == (((int'(year_count[7:4]) * 10 +
                             int'(year_count[3:0])) % 4 == 0) ?
                           `CAL_DAYS_29 : `CAL_DAYS_28))
      else $error("february length wrong");

   leap_flag_a: assert property ( // RL3
      @(posedge sys_clk) disable iff (rst)
      leap_year == ((int'(year_count[7:4]) * 10 +
                     int'(year_count[3:0])) % 4 == 0))
      else $error("leap flag wrong");

   mirror_write_a: assert property ( // RL4
      @(posedge sys_clk) disable iff (rst)
      req.wr && req.addr == `CAL_YEAR_MIR ##1
      req.rd && req.addr == `CAL_YEAR_ADR ##1 1'b1 |->
         rd_data == $past(req.wdata, 2))
      else $error("mirror write not seen at primary");

   user_byte_a: assert property ( // RL5
      @(posedge sys_clk) disable iff (rst)
      req.wr && req.addr == `CAL_RAM_ADR && !month_roll |=>
         user_byte == $past(req.wdata) && $stable(year_count) &&
         $stable(month_count) && $stable(minute_alarm))
      else $error("user byte write misbehaved");

   minute_block_a: assert property ( // RL6
      @(posedge sys_clk) disable iff (rst)
      minute_tick && !minute_alarm[`CAL_DIS_BIT] &&
      now.minute != minute_alarm[`CAL_MIN_MSB:0] |=> !alarm_event)
      else $error("alarm fired on minute mismatch");

   minute_match_a: assert property ( // RL7
      @(posedge sys_clk) disable iff (rst)
      minute_tick && day_alarm_ok && hour_alarm[`CAL_DIS_BIT] &&
      now.minute == minute_alarm[`CAL_MIN_MSB:0] |=> alarm_event)
      else $error("alarm missed on minute match");

   min_write_a: assert property ( // RL7
      @(posedge sys_clk) disable iff (rst)
      req.wr && (req.addr == `CAL_MIN_AL_ADR || req.addr == `CAL_MIN_AL_MIR)
      |=> minute_alarm == $past(req.wdata))
      else $error("minute alarm write not stored");

   hour_ignore_a: assert property ( // RL8
      @(posedge sys_clk) disable iff (rst)
      minute_tick && day_alarm_ok && hour_alarm[`CAL_DIS_BIT] &&
      minute_alarm[`CAL_DIS_BIT] |=> alarm_event)
      else $error("disabled hour still blocked alarm");

   spare_store_a: assert property ( // RL9
      @(posedge sys_clk) disable iff (rst)
      req.wr && req.addr == `CAL_HR_AL_ADR ##1
      req.rd && req.addr == `CAL_HR_AL_MIR |=>
         rd_data[`CAL_SPARE_BIT] == $past(req.wdata[`CAL_SPARE_BIT], 2))
      else $error("spare bit not stored");

   hour_block_a: assert property ( // RL10
      @(posedge sys_clk) disable iff (rst)
      minute_tick && !hour_alarm[`CAL_DIS_BIT] &&
      now.hour != hour_alarm[`CAL_HR_MSB:0] |=> !alarm_event)
      else $error("alarm fired on hour mismatch");

   hour_write_a: assert property ( // RL10
      @(posedge sys_clk) disable iff (rst)
      req.wr && (req.addr == `CAL_HR_AL_ADR || req.addr == `CAL_HR_AL_MIR)
      |=> hour_alarm == $past(req.wdata))
      else $error("hour alarm write not stored");

   alarm_cause_a: assert property ( // RL11
      @(posedge sys_clk) disable iff (rst)
      alarm_event |-> $past(minute_tick) && $past(day_alarm_ok))
      else $error("alarm without minute update");

endmodule : cal_regs

// [testbench/cal_host.sv]
// host-side register master for the calendar and alarm slice
// assumes strobes are taken on the rising edge of sys_clk
`timescale 1ns/1ps

module cal_host
   import cal_pkg::*;
(
   input  wire logic       sys_clk,
   output cal_req_t        req,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid
);
   initial req = '0;

   // idle lines carry the inverse so a stale value never looks live
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [7:0] d,
                     output logic ok);
      @(posedge sys_clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk);
      req <= '{1'b0, 1'b0, ~a, 8'hff};
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         @(posedge sys_clk);
         if (rd_valid === 1'b1)
         begin
            ok = 1'b1;
            d = rd_data;
         end
      end
   endtask : rd

   // write then read on the very next edge, as the bus allows
   task automatic wr_rd(input logic [4:0] a, input logic [7:0] d,
                        input logic [4:0] b, output logic [7:0] v,
                        output logic ok);
      @(posedge sys_clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk);
      req <= '{1'b0, 1'b1, b, ~d};
      @(posedge sys_clk);
      req <= '{1'b0, 1'b0, ~b, d};
      @(posedge sys_clk);
      ok = rd_valid;
      v = rd_data;
   endtask : wr_rd

   // month and year come up as 01 and 00, so load them before use
   task automatic init_cal(input logic [4:0] m, input logic [7:0] y);
      wr(5'h05, {3'h0, m});
      wr(5'h06, y);
   endtask : init_cal
endmodule : cal_host

// [testbench/calendar_alarm_registers_test.sv]
// self-checking bench for the calendar and alarm register slice
// assumes cal_host drives the register requests
`timescale 1ns/1ps

module calendar_alarm_registers_test
   import cal_pkg::*;
;
   logic        sys_clk, rst, rd_valid, minute_tick, month_roll;
   logic        day_alarm_ok, alarm_event, leap_year;
   cal_req_t    req;
   cal_time_t   now;
   logic [7:0]  rd_data, year, d, am, ah, sh [5];
   logic [5:0]  days_in_month, nh;
   logic [6:0]  nm;
   logic [4:0]  month, a;
   logic        ex;
   int          miscompares, cmp_count, k;
   logic [4:0]  tm [8] = '{5'h02, 5'h02, 5'h02, 5'h04, 5'h11, 5'h09,
                           5'h12, 5'h01};
   logic [7:0]  ty [8] = '{8'h24, 8'h23, 8'h00, 8'h10, 8'h98, 8'h01,
                           8'h99, 8'h50};
   logic [4:0]  adr [11] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h16,
                             5'h17, 5'h18, 5'h19, 5'h0a, 5'h1f};

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   cal_regs uut (.sys_clk(sys_clk), .rst(rst), .req(req),
      .rd_data(rd_data), .rd_valid(rd_valid), .now(now),
      .minute_tick(minute_tick), .month_roll(month_roll),
      .day_alarm_ok(day_alarm_ok), .alarm_event(alarm_event),
      .leap_year(leap_year), .days_in_month(days_in_month),
      .month(month), .year(year));

   cal_host host (.sys_clk(sys_clk), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid));

   function automatic logic leap(input logic [7:0] y);
      return ((y[7:4] * 10 + y[3:0]) % 4) == 0;
   endfunction : leap

   function automatic logic [7:0] exp_days(input logic [4:0] m,
                                           input logic [7:0] y);
      if (m == 5'h02)
         return leap(y) ? 8'h29 : 8'h28;
      if (m inside {5'h04, 5'h06, 5'h09, 5'h11})
         return 8'h30;
      return 8'h31;
   endfunction : exp_days

   function automatic int idx(input logic [4:0] x);
      case (x)
         5'h05, 5'h16: return 0;
         5'h06, 5'h17: return 1;
         5'h07:        return 2;
         5'h08, 5'h18: return 3;
         5'h09, 5'h19: return 4;
         default:      return -1;
      endcase
   endfunction : idx

   function automatic logic [4:0] twin(input logic [4:0] x);
      case (x)
         5'h05: return 5'h16;
         5'h16: return 5'h05;
         5'h06: return 5'h17;
         5'h17: return 5'h06;
         5'h08: return 5'h18;
         5'h18: return 5'h08;
         5'h09: return 5'h19;
         5'h19: return 5'h09;
         default: return x;
      endcase
   endfunction : twin

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [4:0] x, input logic [7:0] exp);
      logic [7:0] v;
      logic       ok;
      host.rd(x, v, ok);
      chk({7'h0, ok}, 8'h01, "rd_valid");
      chk(v, exp, "rd_data");
   endtask : rdchk

   task automatic results;
      $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   initial
   begin
      #500000;
      miscompares++;
      results();
   end

   initial
   begin
      rst = 1'b1;
      now = '0;
      minute_tick = 1'b0;
      month_roll = 1'b0;
      day_alarm_ok = 1'b1;
      miscompares = 0;
      cmp_count = 0;
      void'($urandom(32'h35b9_7f4b));
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(5'h07, 8'h00);
      rdchk(5'h18, 8'h00);
      rdchk(5'h09, 8'h00);
      host.init_cal(5'h12, 8'h99);
      @(posedge sys_clk);
      month_roll <= 1'b1;
      @(posedge sys_clk);
      month_roll <= 1'b0;
      @(negedge sys_clk);
      chk({3'h0, month}, 8'h01, "month roll");
      chk(year, 8'h00, "year roll");
      for (k = 0; k < 8; k++)
      begin
         host.init_cal(tm[k], ty[k]);
         @(negedge sys_clk);
         chk({2'h0, days_in_month}, exp_days(tm[k], ty[k]), "days");
         chk({7'h0, leap_year}, {7'h0, leap(ty[k])}, "leap");
      end
      sh = '{8'h01, 8'h50, 8'h00, 8'h00, 8'h00};
      repeat (24)
      begin
         a = adr[$urandom_range(0, 10)];
         d = 8'($urandom);
         host.wr(a, d);
         if (idx(a) >= 0)
            sh[idx(a)] = (idx(a) == 0) ? {3'h0, d[4:0]} : d;
         rdchk(twin(a), (idx(a) >= 0) ? sh[idx(a)] : 8'h00);
      end
      host.wr_rd(5'h17, 8'h25, 5'h06, d, ex);
      chk({7'h0, ex}, 8'h01, "b2b valid");
      chk(d, 8'h25, "b2b mirror");
      host.wr_rd(5'h09, 8'h40, 5'h19, d, ex);
      chk(d, 8'h40, "b2b spare");
      repeat (32)
      begin
         am = 8'($urandom);
         ah = 8'($urandom);
         host.wr(5'h08, am);
         host.wr(5'h19, ah);
         nm = $urandom_range(0, 1) ? am[6:0] : 7'($urandom);
         nh = $urandom_range(0, 1) ? ah[5:0] : 6'($urandom);
         ex = ($urandom_range(0, 3) != 0);
         @(posedge sys_clk);
         now <= '{nm, nh};
         day_alarm_ok <= ex;
         minute_tick <= 1'b1;
         ex = (am[7] | (nm == am[6:0])) & (ah[7] | (nh == ah[5:0])) & ex;
         @(posedge sys_clk);
         minute_tick <= 1'b0;
         @(negedge sys_clk);
         chk({7'h0, alarm_event}, {7'h0, ex}, "alarm");
         @(negedge sys_clk);
         chk({7'h0, alarm_event}, 8'h00, "alarm pulse");
      end
      results();
   end
endmodule : calendar_alarm_registers_test
